// [sirq_map.svh]
// register offsets, field positions and reset values of the sound interrupt controller
`ifndef SIRQ_MAP_SVH
`define SIRQ_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses inside the common data area)
// ----------------------------------------------------------------------------
`define SIRQ_OFS_DMA_CTL   16'h288C
`define SIRQ_OFS_TMR_A     16'h2890
`define SIRQ_OFS_TMR_STEP  16'h0004
`define SIRQ_OFS_SND_EN    16'h289C
`define SIRQ_OFS_SND_PD    16'h28A0
`define SIRQ_OFS_SND_CLR   16'h28A4
`define SIRQ_OFS_SND_LV0   16'h28A8
`define SIRQ_OFS_SND_LV1   16'h28AC
`define SIRQ_OFS_SND_LV2   16'h28B0
`define SIRQ_OFS_HOST_EN   16'h28B4
`define SIRQ_OFS_HOST_PD   16'h28B8
`define SIRQ_OFS_HOST_CLR  16'h28BC
`define SIRQ_OFS_IRQ_NUM   16'h2D00
`define SIRQ_OFS_EOI       16'h2D04

// ----------------------------------------------------------------------------
// source bit positions and field layout
// ----------------------------------------------------------------------------
`define SIRQ_NUM_SRC       11
`define SIRQ_SRC_EXT       0
`define SIRQ_SRC_MIDI_IN   3
`define SIRQ_SRC_DMA       4
`define SIRQ_SRC_SW        5
`define SIRQ_SRC_TMR_A     6
`define SIRQ_SRC_MIDI_OUT  9
`define SIRQ_SRC_SAMPLE    10
`define SIRQ_SRC_VALID     11'h07F9
`define SIRQ_LV_SHARED     7
`define SIRQ_TMR_RATE_LSB  8
`define SIRQ_NUM_LSB       3
`define SIRQ_DMA_GO_BIT    0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SIRQ_RST_SRC       11'h000
`define SIRQ_RST_LV        8'h00
`define SIRQ_RST_TMR_RATE  3'h0
`define SIRQ_RST_TMR_CNT   8'h00

`endif

// [sirq_pkg.sv]
// types shared by the sound interrupt controller and its timers
`default_nettype none
package sirq_pkg;
`include "sirq_map.svh"

    typedef logic [`SIRQ_NUM_SRC-1:0] sirq_src_t;

    typedef enum logic {SIRQ_IDLE, SIRQ_SERVICE} sirq_svc_e;

    typedef struct packed {
        logic [2:0] rate;
        logic [7:0] count;
        logic [6:0] presc;
        logic       wrap;
    } sirq_tmr_s;

    typedef struct packed {
        sirq_src_t  snd_pend;
        sirq_src_t  snd_en;
        sirq_src_t  h_pend;
        sirq_src_t  h_en;
        logic [7:0] lv0;
        logic [7:0] lv1;
        logic [7:0] lv2;
        logic       dma_go;
        logic       mout_d;
        logic       h_req_d;
        sirq_svc_e  svc;
        logic [2:0] svc_level;
        logic [2:0] lvl_n;
        logic       snd_irq;
        logic       host_irq_n;
        logic [15:0] snd_rdata;
        logic [15:0] h_rdata;
    } sirq_state_s;

endpackage
`default_nettype wire

// [sirq_tmr_if.sv]
// link between the controller and one sample-rate timer
`timescale 1ns/1ps
`default_nettype none
interface sirq_tmr_if;
    logic        tick;
    logic        wr;
    logic [10:0] wdata;
    logic [7:0]  count;
    logic [2:0]  rate;
    logic        wrap;

    modport ctrl (output tick, output wr, output wdata, input count, input rate, input wrap);
    modport tmr  (input tick, input wr, input wdata, output count, output rate, output wrap);
endinterface
`default_nettype wire

// [sirq_timer.sv]
// one 8-bit sample-rate timer with a 3-bit rate code
`timescale 1ns/1ps
`default_nettype none
module sirq_timer
    import sirq_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    sirq_tmr_if.tmr   bus
);
`include "sirq_map.svh"

    sirq_tmr_s st;
    sirq_tmr_s next_st;

    // code n gives a prescale of 2**n samples
    function automatic logic [6:0] rate_mask(input logic [2:0] r);
        return 7'((8'h01 << r) - 8'h01);
    endfunction

    always_comb begin
        next_st      = st;
        next_st.wrap = 1'b0;
        if (bus.tick) begin
            if (st.presc == rate_mask(st.rate)) begin
                next_st.presc = 7'h00;
                next_st.count = st.count + 8'h01;
                next_st.wrap  = (st.count == 8'hFF);
            end else begin
                next_st.presc = st.presc + 7'h01;
            end
        end
        // a write restarts the prescaler so a new rate takes effect cleanly
        if (bus.wr) begin
            next_st.rate  = bus.wdata[`SIRQ_TMR_RATE_LSB +: 3];
            next_st.count = bus.wdata[7:0];
            next_st.presc = 7'h00;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{rate: `SIRQ_RST_TMR_RATE, count: `SIRQ_RST_TMR_CNT,
                    presc: 7'h00, wrap: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign bus.count = st.count;
    assign bus.rate  = st.rate;
    assign bus.wrap  = st.wrap;

    AST_TMR_WRAP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        st.wrap && !$past(bus.wr) |-> st.count == 8'h00 && $past(st.count) == 8'hFF)
        else $error("timer wrap flagged without an all-ones to zero step");

    AST_TMR_STEP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        bus.tick && !bus.wr && st.presc == rate_mask(st.rate)
        |=> st.count == 8'($past(st.count) + 8'h01))
        else $error("timer did not advance at the end of its prescale");

    AST_TMR_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !bus.wr && !(bus.tick && st.presc == rate_mask(st.rate)) |=> $stable(st.count))
        else $error("timer moved between prescale ends");

endmodule // sirq_timer
`default_nettype wire

// [sirq_ctrl.sv]
// interrupt controller of the sound block with three sample-rate timers
//
// Summary of operation
// - rate code n steps counter every 2**n samples
// - timer request fires on FF to 00 wrap
// - timers B and C behave like timer A
// - eleven-bit pending map, bits 1-2 reserved
// - MIDI input request follows FIFO holding data
// - MIDI output request on empty, cancelled by write
// - software bit set by writing one, either CPU
// - enable bits gate pending sources per target
// - writing one to clear resets that request
// - three level registers, bit 7 shared by 7-10
// - highest enabled pending level drives active-low level pins
// - host request start gives one-cycle low pulse
// - host interrupt carries no level code
// - interrupt number readable in bits 5 to 3
// - end-of-interrupt write with any of bits 7 to 1 set completes the current interrupt
// - number and end registers sound CPU only
// - DMA end sets pending and clears go flag
// - external request pin feeds bit 0 of both
`timescale 1ns/1ps
`default_nettype none
module sirq_ctrl
    import sirq_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic        ext_irq_input_n_i,
    input  wire logic        midi_in_valid_i,
    input  wire logic        midi_out_empty_i,
    input  wire logic        dma_done_i,
    input  wire logic        sample_tick_i,
    input  wire logic        snd_rd_i,
    input  wire logic        snd_wr_i,
    input  wire logic [15:0] snd_addr_i,
    input  wire logic [15:0] snd_wdata_i,
    output logic      [15:0] snd_rdata_o,
    input  wire logic        host_rd_i,
    input  wire logic        host_wr_i,
    input  wire logic [15:0] host_addr_i,
    input  wire logic [15:0] host_wdata_i,
    output logic      [15:0] host_rdata_o,
    output logic             snd_irq_o,
    output logic             level_out0_n_o,
    output logic             level_out1_n_o,
    output logic             level_out2_n_o,
    output logic             host_irq_out_n_o,
    output logic             dma_go_o
);
`include "sirq_map.svh"

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [15:0] tmr_ofs(input int unsigned i);
        return `SIRQ_OFS_TMR_A + 16'(i * 4);
    endfunction

    function automatic sirq_src_t wmask(input logic wr, input logic [15:0] a,
                                        input logic [15:0] ofs, input logic [15:0] d);
        return (wr && a == ofs) ? d[`SIRQ_NUM_SRC-1:0] : '0;
    endfunction

    // sources 7..10 all take bit 7 of the level registers
    function automatic logic [2:0] level_of(input int unsigned src, input logic [7:0] l0,
                                            input logic [7:0] l1, input logic [7:0] l2);
        int unsigned k;
        k = (src > `SIRQ_LV_SHARED) ? `SIRQ_LV_SHARED : src;
        return {l2[k], l1[k], l0[k]};
    endfunction

    // set beats clear: events are ORed in after the clear mask is applied
    function automatic sirq_src_t upd_pend(input sirq_src_t cur, input sirq_src_t clr,
                                           input logic sw, input sirq_src_t ev,
                                           input logic midi_in, input logic mout_fall);
        sirq_src_t n;
        n = (cur & ~clr) | ev;
        if (sw) begin
            n[`SIRQ_SRC_SW] = 1'b1;
        end
        n[`SIRQ_SRC_MIDI_IN] = midi_in;
        if (mout_fall) begin
            n[`SIRQ_SRC_MIDI_OUT] = 1'b0;
        end
        return n & `SIRQ_SRC_VALID;
    endfunction

    function automatic logic [15:0] rd_word(input sirq_state_s s,
                                            input logic [2:0][10:0] tv,
                                            input logic [15:0] a, input logic from_snd);
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            `SIRQ_OFS_DMA_CTL:  r[`SIRQ_DMA_GO_BIT] = s.dma_go;
            `SIRQ_OFS_TMR_A:    r[10:0] = tv[0];
            tmr_ofs(1):         r[10:0] = tv[1];
            tmr_ofs(2):         r[10:0] = tv[2];
            `SIRQ_OFS_SND_EN:   r[10:0] = s.snd_en;
            `SIRQ_OFS_SND_PD:   r[10:0] = s.snd_pend;
            `SIRQ_OFS_SND_LV0:  r[7:0]  = s.lv0;
            `SIRQ_OFS_SND_LV1:  r[7:0]  = s.lv1;
            `SIRQ_OFS_SND_LV2:  r[7:0]  = s.lv2;
            `SIRQ_OFS_HOST_EN:  r[10:0] = s.h_en;
            `SIRQ_OFS_HOST_PD:  r[10:0] = s.h_pend;
            `SIRQ_OFS_IRQ_NUM: begin
                if (from_snd && s.svc == SIRQ_SERVICE) begin
                    r[`SIRQ_NUM_LSB +: 3] = s.svc_level;
                end
            end
            default:            r = 16'h0000;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------------
    sirq_tmr_if tif[3] ();

    logic [2:0]       tmr_wr;
    logic [2:0][10:0] tmr_wdata;
    logic [2:0][10:0] tmr_val;
    logic [2:0]       tmr_wrap;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            tmr_wr[i]    = (snd_wr_i && snd_addr_i == tmr_ofs(i))
                         || (host_wr_i && host_addr_i == tmr_ofs(i));
            // the sound CPU wins if both sides write the same timer at once
            tmr_wdata[i] = (snd_wr_i && snd_addr_i == tmr_ofs(i))
                         ? snd_wdata_i[10:0] : host_wdata_i[10:0];
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_tmr
        assign tif[g].tick  = sample_tick_i;
        assign tif[g].wr    = tmr_wr[g];
        assign tif[g].wdata = tmr_wdata[g];
        assign tmr_val[g]   = {tif[g].rate, tif[g].count};
        assign tmr_wrap[g]  = tif[g].wrap;

        sirq_timer u_tmr (
            .clock_i (clock_i),
            .rst_b_i (rst_b_i),
            .bus     (tif[g])
        );
    end

    // ------------------------------------------------------------------------
    // controller state
    // ------------------------------------------------------------------------
    sirq_state_s st;
    sirq_state_s next_st;
    sirq_src_t   snd_act;
    sirq_src_t   h_act;
    sirq_src_t   ev;
    logic [2:0]  best;
    logic        eoi;

    assign snd_act = st.snd_pend & st.snd_en;
    assign h_act   = st.h_pend & st.h_en;
    assign eoi     = snd_wr_i && snd_addr_i == `SIRQ_OFS_EOI
                   && (|snd_wdata_i[7:1]);

    always_comb begin
        best = 3'h0;
        for (int unsigned s = 0; s < `SIRQ_NUM_SRC; s++) begin
            if (snd_act[s] && level_of(s, st.lv0, st.lv1, st.lv2) > best) begin
                best = level_of(s, st.lv0, st.lv1, st.lv2);
            end
        end
    end

    always_comb begin
        ev                     = '0;
        ev[`SIRQ_SRC_EXT]      = ~ext_irq_input_n_i;
        ev[`SIRQ_SRC_DMA]      = dma_done_i;
        ev[`SIRQ_SRC_TMR_A+:3] = tmr_wrap;
        ev[`SIRQ_SRC_MIDI_OUT] = midi_out_empty_i & ~st.mout_d;
        ev[`SIRQ_SRC_SAMPLE]   = sample_tick_i;
    end

    always_comb begin
        sirq_src_t snd_clr;
        sirq_src_t host_clr;
        sirq_src_t sw_snd;
        sirq_src_t sw_host;
        logic      mout_fall;
        snd_clr   = wmask(snd_wr_i, snd_addr_i, `SIRQ_OFS_SND_CLR, snd_wdata_i)
                  | wmask(host_wr_i, host_addr_i, `SIRQ_OFS_SND_CLR, host_wdata_i);
        host_clr  = wmask(snd_wr_i, snd_addr_i, `SIRQ_OFS_HOST_CLR, snd_wdata_i)
                  | wmask(host_wr_i, host_addr_i, `SIRQ_OFS_HOST_CLR, host_wdata_i);
        sw_snd    = wmask(snd_wr_i, snd_addr_i, `SIRQ_OFS_SND_PD, snd_wdata_i)
                  | wmask(host_wr_i, host_addr_i, `SIRQ_OFS_SND_PD, host_wdata_i);
        sw_host   = wmask(snd_wr_i, snd_addr_i, `SIRQ_OFS_HOST_PD, snd_wdata_i)
                  | wmask(host_wr_i, host_addr_i, `SIRQ_OFS_HOST_PD, host_wdata_i);
        mout_fall = ~midi_out_empty_i & st.mout_d;
        next_st   = st;

        next_st.snd_pend = upd_pend(st.snd_pend, snd_clr, sw_snd[`SIRQ_SRC_SW], ev,
                                    midi_in_valid_i, mout_fall);
        next_st.h_pend   = upd_pend(st.h_pend, host_clr, sw_host[`SIRQ_SRC_SW], ev,
                                    midi_in_valid_i, mout_fall);
        next_st.mout_d   = midi_out_empty_i;

        // enable and level registers, sound CPU port written last so it wins
        if (host_wr_i && host_addr_i == `SIRQ_OFS_SND_EN) begin
            next_st.snd_en = host_wdata_i[10:0] & `SIRQ_SRC_VALID;
        end
        if (snd_wr_i && snd_addr_i == `SIRQ_OFS_SND_EN) begin
            next_st.snd_en = snd_wdata_i[10:0] & `SIRQ_SRC_VALID;
        end
        if (host_wr_i && host_addr_i == `SIRQ_OFS_HOST_EN) begin
            next_st.h_en = host_wdata_i[10:0] & `SIRQ_SRC_VALID;
        end
        if (snd_wr_i && snd_addr_i == `SIRQ_OFS_HOST_EN) begin
            next_st.h_en = snd_wdata_i[10:0] & `SIRQ_SRC_VALID;
        end
        for (int p = 0; p < 2; p++) begin
            logic        w;
            logic [15:0] a;
            logic [15:0] d;
            w = (p == 0) ? host_wr_i : snd_wr_i;
            a = (p == 0) ? host_addr_i : snd_addr_i;
            d = (p == 0) ? host_wdata_i : snd_wdata_i;
            if (w && a == `SIRQ_OFS_SND_LV0) next_st.lv0 = d[7:0];
            if (w && a == `SIRQ_OFS_SND_LV1) next_st.lv1 = d[7:0];
            if (w && a == `SIRQ_OFS_SND_LV2) next_st.lv2 = d[7:0];
        end

        // a fresh start written in the same cycle as the end takes precedence
        if (dma_done_i) begin
            next_st.dma_go = 1'b0;
        end
        if ((snd_wr_i && snd_addr_i == `SIRQ_OFS_DMA_CTL && snd_wdata_i[`SIRQ_DMA_GO_BIT])
         || (host_wr_i && host_addr_i == `SIRQ_OFS_DMA_CTL
             && host_wdata_i[`SIRQ_DMA_GO_BIT])) begin
            next_st.dma_go = 1'b1;
        end

        // sound CPU delivery: live level on the pins, number latched until end
        next_st.snd_irq = |snd_act;
        next_st.lvl_n   = (|snd_act) ? ~best : 3'h7;
        case (st.svc)
            SIRQ_IDLE: begin
                if (|snd_act) begin
                    next_st.svc       = SIRQ_SERVICE;
                    next_st.svc_level = best;
                end
            end
            SIRQ_SERVICE: begin
                if (eoi) begin
                    next_st.svc = SIRQ_IDLE;
                end
            end
            default: next_st.svc = SIRQ_IDLE;
        endcase

        // host side: no level code, just a one-cycle low pulse on a new request
        next_st.h_req_d    = |h_act;
        next_st.host_irq_n = ~((|h_act) & ~st.h_req_d);

        if (snd_rd_i) begin
            next_st.snd_rdata = rd_word(st, tmr_val, snd_addr_i, 1'b1);
        end
        if (host_rd_i) begin
            next_st.h_rdata = rd_word(st, tmr_val, host_addr_i, 1'b0);
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{snd_pend: `SIRQ_RST_SRC, snd_en: `SIRQ_RST_SRC,
                    h_pend: `SIRQ_RST_SRC, h_en: `SIRQ_RST_SRC,
                    lv0: `SIRQ_RST_LV, lv1: `SIRQ_RST_LV, lv2: `SIRQ_RST_LV,
                    dma_go: 1'b0, mout_d: 1'b1, h_req_d: 1'b0, svc: SIRQ_IDLE,
                    svc_level: 3'h0, lvl_n: 3'h7, snd_irq: 1'b0, host_irq_n: 1'b1,
                    snd_rdata: 16'h0000, h_rdata: 16'h0000};
        end else begin
            st <= next_st;
        end
    end

    assign snd_rdata_o      = st.snd_rdata;
    assign host_rdata_o     = st.h_rdata;
    assign snd_irq_o        = st.snd_irq;
    assign level_out0_n_o   = st.lvl_n[0];
    assign level_out1_n_o   = st.lvl_n[1];
    assign level_out2_n_o   = st.lvl_n[2];
    assign host_irq_out_n_o = st.host_irq_n;
    assign dma_go_o         = st.dma_go;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    sequence s_hreq_rise;
        (|h_act) && !st.h_req_d;
    endsequence

    sequence s_low_pulse;
        !host_irq_out_n_o ##1 host_irq_out_n_o;
    endsequence

    sequence s_eoi_in_service;
        st.svc == SIRQ_SERVICE ##0 eoi;
    endsequence

    AST_HOST_PULSE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_hreq_rise |=> s_low_pulse)
        else $error("host interrupt pulse not exactly one cycle low");

    AST_EOI: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_eoi_in_service |=> st.svc == SIRQ_IDLE ##1 (st.svc == SIRQ_SERVICE) == ($past(snd_act) != '0))
        else $error("end of interrupt did not release the current interrupt");

    AST_SW_SET: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        host_wr_i && host_addr_i == `SIRQ_OFS_SND_PD && host_wdata_i[`SIRQ_SRC_SW]
        |=> st.snd_pend[`SIRQ_SRC_SW])
        else $error("software request not set by host write");

    AST_CLR: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        snd_wr_i && snd_addr_i == `SIRQ_OFS_SND_CLR && snd_wdata_i[`SIRQ_SRC_TMR_A]
        && !tmr_wrap[0] |=> !st.snd_pend[`SIRQ_SRC_TMR_A])
        else $error("clear write did not reset the pending request");

    AST_MIDI_IN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        1'b1 |=> st.snd_pend[`SIRQ_SRC_MIDI_IN] == $past(midi_in_valid_i)
                 && st.h_pend[`SIRQ_SRC_MIDI_IN] == $past(midi_in_valid_i))
        else $error("MIDI input request does not follow the FIFO");

    AST_DMA_END: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        dma_done_i && !snd_wr_i && !host_wr_i
        |=> st.snd_pend[`SIRQ_SRC_DMA] && st.h_pend[`SIRQ_SRC_DMA] && !dma_go_o)
        else $error("DMA end did not set pending and drop the go flag");

    AST_IDLE_PINS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !(|snd_act) |=> !snd_irq_o && level_out0_n_o && level_out1_n_o && level_out2_n_o)
        else $error("level pins active with no enabled request");

    AST_RESERVED: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        st.snd_pend[2:1] == 2'b00 && st.h_pend[2:1] == 2'b00)
        else $error("reserved pending bits set");

    AST_MOUT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !midi_out_empty_i && st.mout_d |=> !st.snd_pend[`SIRQ_SRC_MIDI_OUT])
        else $error("MIDI output request not cancelled by a new write");

endmodule // sirq_ctrl
`default_nettype wire

// [sirq_far_end.sv]
// far-side model: MIDI FIFO fill levels seen by the controller
`timescale 1ns/1ps
`default_nettype none
module sirq_far_end (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic rx_push_i,
    input  wire logic rx_pop_i,
    input  wire logic tx_push_i,
    output logic      midi_in_valid_o,
    output logic      midi_out_empty_o
);
    logic [2:0] rx_cnt;
    logic [2:0] tx_cnt;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_cnt <= 3'h0;
            tx_cnt <= 3'h0;
        end else begin
            rx_cnt <= rx_cnt + 3'(rx_push_i) - 3'(rx_pop_i && rx_cnt != 3'h0);
            // the sender drains one byte a cycle, so empty returns quickly
            tx_cnt <= tx_cnt + 3'(tx_push_i) - 3'(tx_cnt != 3'h0);
        end
    end
    assign midi_in_valid_o  = (rx_cnt != 3'h0);
    assign midi_out_empty_o = (tx_cnt == 3'h0);
endmodule // sirq_far_end
`default_nettype wire

// [testbench.sv]
// self-checking bench of the sound interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_i = 0, rst_b_i = 0, ext_n = 1, dma_done = 0, tick = 0;
    logic rx_push = 0, rx_pop = 0, tx_push = 0, in_valid, out_empty;
    logic snd_rd = 0, snd_wr = 0, h_rd = 0, h_wr = 0, snd_irq, hirq_n, go, l0, l1, l2;
    logic [15:0] snd_a = 0, snd_d = 0, h_a = 0, h_d = 0, snd_q, h_q;
    int num_errors = 0, checks = 0;
    always #25 clock_i = ~clock_i;
    sirq_far_end FAR (.clock_i(clock_i), .rst_b_i(rst_b_i), .rx_push_i(rx_push),
        .rx_pop_i(rx_pop), .tx_push_i(tx_push), .midi_in_valid_o(in_valid),
        .midi_out_empty_o(out_empty));
    sirq_ctrl DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .ext_irq_input_n_i(ext_n),
        .midi_in_valid_i(in_valid), .midi_out_empty_i(out_empty), .dma_done_i(dma_done),
        .sample_tick_i(tick), .snd_rd_i(snd_rd), .snd_wr_i(snd_wr), .snd_addr_i(snd_a),
        .snd_wdata_i(snd_d), .snd_rdata_o(snd_q), .host_rd_i(h_rd), .host_wr_i(h_wr),
        .host_addr_i(h_a), .host_wdata_i(h_d), .host_rdata_o(h_q), .snd_irq_o(snd_irq),
        .level_out0_n_o(l0), .level_out1_n_o(l1), .level_out2_n_o(l2),
        .host_irq_out_n_o(hirq_n), .dma_go_o(go));
    task automatic complete_run;
        if (num_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input bit h, input bit w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clock_i);
        if (h) begin h_wr <= w; h_rd <= !w; h_a <= a; h_d <= d; end
        else begin snd_wr <= w; snd_rd <= !w; snd_a <= a; snd_d <= d; end
        @(posedge clock_i);
        {h_wr, h_rd, snd_wr, snd_rd} <= 4'h0;
    endtask
    task automatic rd(input bit h, input logic [15:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        acc(h, 0, a, 16'h0000);
        #1 chk((h ? h_q : snd_q) & m, e);
    endtask
    task automatic t_sw;
        rd(0, 16'h28A0, 16'hFFFF, 16'h0000);
        rd(1, 16'h2800, 16'hFFFF, 16'h0000);
        acc(1, 1, 16'h28A0, 16'h0000);
        rd(0, 16'h28A0, 16'hFFFF, 16'h0000);
        acc(1, 1, 16'h28A0, 16'h0020);
        rd(0, 16'h28A0, 16'hFFFF, 16'h0020);
        acc(0, 1, 16'h289C, 16'h0020);
        repeat (2) @(posedge clock_i);
        #1 chk({15'h0, snd_irq}, 16'h0001);
        acc(0, 1, 16'h28A4, 16'h0020);
        rd(0, 16'h28A0, 16'hFFFF, 16'h0000);
    endtask
    task automatic t_host;
        int n = 0;
        acc(1, 1, 16'h28B4, 16'h0020);
        acc(0, 1, 16'h28B8, 16'h0020);
        repeat (6) begin @(negedge clock_i); n += int'(!hirq_n); end
        chk(16'(n), 16'h0001);
        acc(1, 1, 16'h28BC, 16'h0020);
    endtask
    task automatic t_timer;
        acc(0, 1, 16'h2890, 16'h01FE);
        acc(0, 1, 16'h2894, 16'h00FF);
        acc(0, 1, 16'h2898, 16'h02FF);
        repeat (4) begin @(posedge clock_i) tick <= 1; @(posedge clock_i) tick <= 0; end
        rd(0, 16'h2890, 16'h07FF, 16'h0100);
        rd(0, 16'h2894, 16'h07FF, 16'h0003);
        rd(0, 16'h2898, 16'h07FF, 16'h0200);
        rd(0, 16'h28A0, 16'h0440, 16'h0440);
        rd(0, 16'h28A0, 16'h0180, 16'h0180);
    endtask
    task automatic t_level;
        acc(0, 1, 16'h28A4, 16'h07FF);
        acc(0, 1, 16'h289C, 16'h0001);
        acc(0, 1, 16'h28A8, 16'h0001);
        acc(0, 1, 16'h28B0, 16'h0001);
        // leave the service entered by the software request earlier
        acc(0, 1, 16'h2D04, 16'h0002);
        @(posedge clock_i) ext_n <= 0;
        @(posedge clock_i) ext_n <= 1;
        repeat (3) @(posedge clock_i);
        #1 chk({12'h0, snd_irq, l2, l1, l0}, 16'h000A);
        rd(0, 16'h2D00, 16'hFFFF, 16'h0028);
        rd(1, 16'h2D00, 16'hFFFF, 16'h0000);
        acc(0, 1, 16'h28A4, 16'h0001);
        acc(0, 1, 16'h2D04, 16'h0002);
        repeat (3) @(posedge clock_i);
        #1 chk({12'h0, snd_irq, l2, l1, l0}, 16'h0007);
        rd(0, 16'h2D00, 16'hFFFF, 16'h0000);
    endtask
    task automatic t_midi_dma;
        @(posedge clock_i) rx_push <= 1;
        @(posedge clock_i) rx_push <= 0;
        rd(0, 16'h28A0, 16'h0008, 16'h0008);
        @(posedge clock_i) rx_pop <= 1;
        @(posedge clock_i) rx_pop <= 0;
        rd(0, 16'h28A0, 16'h0008, 16'h0000);
        @(posedge clock_i) tx_push <= 1;
        @(posedge clock_i) tx_push <= 0;
        // empty returns one edge after the push and pends one edge later
        @(posedge clock_i);
        rd(1, 16'h28B8, 16'h0200, 16'h0200);
        @(posedge clock_i) tx_push <= 1;
        @(posedge clock_i) tx_push <= 0;
        rd(1, 16'h28B8, 16'h0200, 16'h0000);
        acc(0, 1, 16'h288C, 16'h0001);
        #1 chk({15'h0, go}, 16'h0001);
        @(posedge clock_i) dma_done <= 1;
        @(posedge clock_i) dma_done <= 0;
        rd(0, 16'h28A0, 16'h0010, 16'h0010);
        chk({15'h0, go}, 16'h0000);
    endtask
    initial begin
        #2_000_000;
        num_errors++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge clock_i);
        rst_b_i <= 1;
        t_sw;
        t_host;
        t_timer;
        t_level;
        t_midi_dma;
        complete_run;
    end
endmodule // testbench
`default_nettype wire
